// *** rtl/omi_top.sv ***
// Purpose: optical module status, control and serial management master
// Assumes: APB slave on pclk, module pins asynchronous to pclk
// Notes: one two-wire bus per port, only the selected port is driven
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "omi_cfg.svh"
module omi_top
  import omi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // module status and control pins
  input wire logic [`OMI_NPORTS-1:0] loss_of_signal_in,
  input wire logic [`OMI_NPORTS-1:0] tx_fault_in,
  input wire logic [`OMI_NPORTS-1:0] module_present_in,
  output logic [`OMI_NPORTS-1:0] tx_disable,
  // two-wire management lines
  output logic [`OMI_NPORTS-1:0] scl_out,
  output logic [`OMI_NPORTS-1:0] scl_oe,
  input wire logic [`OMI_NPORTS-1:0] sda_in,
  output logic [`OMI_NPORTS-1:0] sda_out,
  output logic [`OMI_NPORTS-1:0] sda_oe,
  // interrupt
  output logic irq
);

  localparam int NP = `OMI_NPORTS;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3*NP-1:0] pin_m_q;
  logic [3*NP-1:0] pin_s_q;
  logic [3*NP-1:0] pin_p_q;
  logic [NP-1:0] sda_m_q;
  logic [NP-1:0] sda_s_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
      sda_m_q <= '1;
      sda_s_q <= '1;
    end else begin
      pin_m_q <= {loss_of_signal_in, tx_fault_in, module_present_in};
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  wire [NP-1:0] los_s = pin_s_q[3*NP-1:2*NP];
  wire [NP-1:0] fault_s = pin_s_q[2*NP-1:NP];
  wire [NP-1:0] pres_s = pin_s_q[NP-1:0];
  wire [NP-1:0] los_p = pin_p_q[3*NP-1:2*NP];
  wire [NP-1:0] fault_p = pin_p_q[2*NP-1:NP];
  wire [NP-1:0] pres_p = pin_p_q[NP-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  function automatic logic hit(logic [15:0] a, logic [11:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  wire acc = psel && penable;
  wire fin = acc && pready_q;
  wire h_modstat = hit(paddr, `OMI_IDX_MODSTAT);
  wire h_modctl = hit(paddr, `OMI_IDX_MODCTL);
  wire h_smctl = hit(paddr, `OMI_IDX_SMCTL);
  wire h_smdata = hit(paddr, `OMI_IDX_SMDATA);
  wire h_irqstat = hit(paddr, `OMI_IDX_IRQSTAT);
  wire h_irqmask = hit(paddr, `OMI_IDX_IRQMASK);
  wire h_any = h_modstat | h_modctl | h_smctl | h_smdata | h_irqstat | h_irqmask;
  wire wr_fin = fin && pwrite;
  wire rd_fin = fin && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic en_los_q;
  logic en_fault_q;
  logic en_pres_q;
  logic [NP-1:0] txdis_q;
  logic sm_en_q;
  logic start_q;
  logic porterr_q;
  logic wperr_q;
  logic nakerr_q;
  logic wrdone_q;
  logic rdvalid_q;
  logic [3:0] port_q;
  logic dir_q;
  logic [3:0] devid_q;
  logic [10:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic irq_q;

  omi_seq_type st_q;
  wire idle = (st_q == S_IDLE);

  // requested cycle, checked before anything reaches the line
  wire smctl_wr = wr_fin && h_smctl;
  wire [3:0] port_new = pwdata[`OMI_PORT_LSB+3:`OMI_PORT_LSB];
  wire dir_new = pwdata[`OMI_DIR];
  wire [3:0] devid_new = pwdata[`OMI_DEVID_LSB+3:`OMI_DEVID_LSB];
  wire launch_req = smctl_wr && pwdata[`OMI_START] && pwdata[`OMI_ENABLE] && idle;
  wire bad_port = port_new > `OMI_MAX_PORT;
  wire wp_hit = !dir_new && (devid_new == `OMI_WP_DEVID) && (pwdata[10:8] == 3'b000);
  wire launch_ok = launch_req && !bad_port && !wp_hit;
  wire seq_end;
  wire seq_nak;

  // change of an enabled class on any port
  wire ev_los = en_los_q && |(los_s ^ los_p);
  wire ev_fault = en_fault_q && |(fault_s ^ fault_p);
  wire ev_pres = en_pres_q && |(pres_s ^ pres_p);
  wire ev_cyc = seq_end || (launch_req && !launch_ok);
  wire [3:0] ev = {ev_cyc, ev_los, ev_fault, ev_pres};
  wire [3:0] stat_clr = (wr_fin && h_irqstat) ? pwdata[3:0] : 4'h0;
  // set wins over a write-one clear in the same cycle
  wire [3:0] stat_d = (stat_q & ~stat_clr) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_los_q <= 1'b0;
      en_fault_q <= 1'b0;
      en_pres_q <= 1'b0;
      txdis_q <= '0;
      mask_q <= 4'h0;
      stat_q <= 4'h0;
      irq_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      if (wr_fin && h_modctl) begin
        en_los_q <= pwdata[`OMI_EN_LOS];
        en_fault_q <= pwdata[`OMI_EN_FAULT];
        en_pres_q <= pwdata[`OMI_EN_PRES];
        txdis_q <= pwdata[NP-1:0];
      end
      if (wr_fin && h_irqmask) begin
        mask_q <= pwdata[3:0];
      end
      if (wr_fin && h_smdata) begin
        wdata_q <= pwdata[`OMI_WDATA_LSB+7:`OMI_WDATA_LSB];
      end
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // management control; port, direction, device id and address fields are frozen while a cycle runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm_en_q <= 1'b0;
      start_q <= 1'b0;
      porterr_q <= 1'b0;
      wperr_q <= 1'b0;
      nakerr_q <= 1'b0;
      wrdone_q <= 1'b0;
      rdvalid_q <= 1'b0;
      port_q <= 4'h0;
      dir_q <= `OMI_DIR_RST;
      devid_q <= `OMI_DEVID_RST;
      addr_q <= 11'h000;
    end else begin
      if (smctl_wr && pwdata[`OMI_START]) begin
        start_q <= 1'b1;
      end else if (rd_fin && h_smctl) begin
        start_q <= 1'b0;
      end
      if (smctl_wr) begin
        sm_en_q <= pwdata[`OMI_ENABLE];
      end
      if (smctl_wr && idle) begin
        port_q <= port_new;
        dir_q <= dir_new;
        devid_q <= devid_new;
        addr_q <= pwdata[10:0];
      end
      if (launch_req) begin
        porterr_q <= bad_port;
        wperr_q <= !bad_port && wp_hit;
        nakerr_q <= 1'b0;
        wrdone_q <= 1'b0;
        rdvalid_q <= 1'b0;
      end else if (seq_nak) begin
        nakerr_q <= 1'b1;
      end else if (seq_end && !nakerr_q) begin
        wrdone_q <= !dir_q;
        rdvalid_q <= dir_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte sequencer

  omi_tw_if tw ();

  logic req_q;
  omi_bitcmd_type cmd_q;
  logic txbit_q;
  logic [1:0] stage_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;

  wire [7:0] dev_w = {devid_q, addr_q[10:8], 1'b0};
  wire [7:0] dev_r = {devid_q, addr_q[10:8], 1'b1};
  wire step = tw.done;
  assign seq_end = step && (st_q == S_STOP);
  assign seq_nak = step && (st_q == S_ACK) && tw.rxbit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      req_q <= 1'b0;
      cmd_q <= BC_STOP;
      txbit_q <= 1'b1;
      stage_q <= 2'd0;
      bit_q <= 3'd7;
      sh_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      req_q <= 1'b0;
      if (launch_ok) begin
        st_q <= S_START;
        stage_q <= 2'd0;
        sh_q <= {devid_new, pwdata[10:8], 1'b0};
        req_q <= 1'b1;
        cmd_q <= BC_START;
      end else if (step) begin
        req_q <= 1'b1;
        unique case (st_q)
          S_START: begin
            st_q <= S_TX;
            bit_q <= 3'd7;
            cmd_q <= BC_WRITE;
            txbit_q <= sh_q[7];
          end
          S_TX: begin
            if (bit_q == 3'd0) begin
              st_q <= S_ACK;
              cmd_q <= BC_READ;
            end else begin
              bit_q <= bit_q - 3'd1;
              sh_q <= {sh_q[6:0], 1'b0};
              cmd_q <= BC_WRITE;
              txbit_q <= sh_q[6];
            end
          end
          S_ACK: begin
            bit_q <= 3'd7;
            if (tw.rxbit) begin
              st_q <= S_STOP;
              cmd_q <= BC_STOP;
            end else if (stage_q == 2'd0) begin
              st_q <= S_TX;
              stage_q <= 2'd1;
              sh_q <= addr_q[7:0];
              cmd_q <= BC_WRITE;
              txbit_q <= addr_q[7];
            end else if (stage_q == 2'd1 && !dir_q) begin
              st_q <= S_TX;
              stage_q <= 2'd2;
              sh_q <= wdata_q;
              cmd_q <= BC_WRITE;
              txbit_q <= wdata_q[7];
            end else if (stage_q == 2'd1) begin
              st_q <= S_START;
              stage_q <= 2'd3;
              sh_q <= dev_r;
              cmd_q <= BC_START;
            end else if (stage_q == 2'd2) begin
              st_q <= S_STOP;
              cmd_q <= BC_STOP;
            end else begin
              st_q <= S_RX;
              cmd_q <= BC_READ;
            end
          end
          S_RX: begin
            sh_q <= {sh_q[6:0], tw.rxbit};
            if (bit_q == 3'd0) begin
              st_q <= S_MNACK;
              cmd_q <= BC_WRITE;
              txbit_q <= 1'b1;
            end else begin
              bit_q <= bit_q - 3'd1;
              cmd_q <= BC_READ;
            end
          end
          S_MNACK: begin
            rdata_q <= sh_q;
            st_q <= S_STOP;
            cmd_q <= BC_STOP;
          end
          S_STOP: begin
            st_q <= S_IDLE;
            req_q <= 1'b0;
          end
          S_IDLE: begin
            req_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign tw.req = req_q;
  assign tw.cmd = cmd_q;
  assign tw.txbit = txbit_q;
  assign tw.port = port_q;
  // only the second synchroniser stage feeds the engine
  assign tw.sda_line = sda_s_q[port_q];

  omi_twowire u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .tw(tw.engine),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb answer

  wire [31:0] rd_modstat = {2'b00, los_s, fault_s, pres_s};
  wire [31:0] rd_modctl = {19'h00000, en_los_q, en_fault_q, en_pres_q, txdis_q};
  wire [31:0] rd_smctl = {3'b000, porterr_q, wperr_q, nakerr_q, sm_en_q, start_q, 1'b0,
                          wrdone_q, 1'b0, rdvalid_q, port_q, dir_q, devid_q, addr_q};
  wire [31:0] rd_smdata = {8'h00, wdata_q, 8'h00, rdata_q};
  wire [31:0] rd_mux = h_modstat ? rd_modstat :
                       h_modctl ? rd_modctl :
                       h_smctl ? rd_smctl :
                       h_smdata ? rd_smdata :
                       h_irqstat ? {28'h0000000, stat_q} :
                       h_irqmask ? {28'h0000000, mask_q} : 32'h00000000;

  // one wait state keeps prdata a clean flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !h_any;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // open-drain lines only ever pull low
  logic [NP-1:0] low_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= '0;
    end else begin
      low_q <= '0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_disable = txdis_q;
  assign irq = irq_q;
  assign scl_out = low_q;
  assign sda_out = low_q;

endmodule // omi_top

// *** rtl/omi_cfg.svh ***
// Purpose: constants of the optical module management block
// Assumes: 100 MHz pclk, APB word registers at four times the index
// Notes: Operation list below, then offsets, fields, resets and timing
//
// Operation
// - status word shows live loss-of-signal of ports 0-9 in bits 29:20
// - status word shows live transmitter fault of ports 0-9 in bits 19:10
// - status word shows live module presence of ports 0-9 in bits 9:0
// - bit 12 enables loss-of-signal interrupt class, resets to 0
// - bit 11 enables transmitter fault interrupt class, resets to 0
// - bit 10 enables module presence interrupt class, resets to 0
// - ten control bits drive the per-port transmitter-disable outputs, reset 0
// - access to a port above nine sets the port address error flag
// - write to device id 0xa with address bits 10:8 zero sets write-protect error
// - missing module acknowledge sets no-ack error; read data valid only when clear
// - enable bit 25 permits serial accesses; reset 0 blocks them all
// - writing 1 to start launches a cycle; start clears when register read
// - write-complete flag sets when a byte write cycle finishes
// - read-valid flag sets when a received byte sits in the read field
// - four-bit field 19:16 selects the port addressed by the cycle
// - direction bit 15 reset 1, device id 14:11 reset 0xa, 10:0 address
// - data word: write byte in 23:16, last read byte in 7:0
`ifndef OMI_CFG_SVH
`define OMI_CFG_SVH

`define OMI_NPORTS 10
`define OMI_IDX_MODSTAT 12'h799
`define OMI_IDX_MODCTL 12'h79a
`define OMI_IDX_SMCTL 12'h79b
`define OMI_IDX_SMDATA 12'h79c
`define OMI_IDX_IRQSTAT 12'h79d
`define OMI_IDX_IRQMASK 12'h79e

`define OMI_LOS_LSB 20
`define OMI_FAULT_LSB 10
`define OMI_PRES_LSB 0
`define OMI_EN_LOS 12
`define OMI_EN_FAULT 11
`define OMI_EN_PRES 10

`define OMI_PORTERR 28
`define OMI_WPERR 27
`define OMI_NAKERR 26
`define OMI_ENABLE 25
`define OMI_START 24
`define OMI_WRDONE 22
`define OMI_RDVALID 20
`define OMI_PORT_LSB 16
`define OMI_DIR 15
`define OMI_DEVID_LSB 11
`define OMI_WDATA_LSB 16

`define OMI_DIR_RST 1'b1
`define OMI_DEVID_RST 4'ha
`define OMI_WP_DEVID 4'ha
`define OMI_MAX_PORT 4'h9

`define OMI_IRQ_PRES 0
`define OMI_IRQ_FAULT 1
`define OMI_IRQ_LOS 2
`define OMI_IRQ_CYC 3

`define OMI_CLK_NS 10
`define OMI_SCL_QTR_NS 2500
`define OMI_SCL_QTR_CYC ((`OMI_SCL_QTR_NS) / (`OMI_CLK_NS))

`endif

// *** rtl/omi_pkg.sv ***
// Purpose: types of the optical module management block
// Assumes: nothing
// Notes: bit commands and sequencer states
package omi_pkg;

  typedef enum logic [1:0] {
    BC_START,
    BC_STOP,
    BC_WRITE,
    BC_READ
  } omi_bitcmd_type;

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_TX,
    S_ACK,
    S_RX,
    S_MNACK,
    S_STOP
  } omi_seq_type;

endpackage

// *** rtl/omi_tw_if.sv ***
// Purpose: link between byte sequencer and two-wire bit engine
// Assumes: single pclk domain
// Notes: req is a one-cycle pulse, taken only while the engine is idle
`timescale 1ns/10ps
interface omi_tw_if;
  import omi_pkg::*;
  logic req;
  omi_bitcmd_type cmd;
  logic txbit;
  logic [3:0] port;
  logic sda_line;
  logic done;
  logic rxbit;
  modport seq (output req, output cmd, output txbit, output port, output sda_line,
               input done, input rxbit);
  modport engine (input req, input cmd, input txbit, input port, input sda_line,
                  output done, output rxbit);
endinterface

// *** rtl/omi_twowire.sv ***
// Purpose: two-wire bit engine, one start, stop or data bit per request
// Assumes: open-drain lines, oe high pulls the selected port low
// Notes: each bit is four quarter periods of the serial clock
`timescale 1ns/10ps
`include "omi_cfg.svh"
module omi_twowire
  import omi_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  omi_tw_if.engine tw,
  // line drivers
  output logic [`OMI_NPORTS-1:0] scl_oe,
  output logic [`OMI_NPORTS-1:0] sda_oe
);

  localparam logic [7:0] QTR_LAST = 8'(`OMI_SCL_QTR_CYC - 1);

  logic busy_q;
  logic [7:0] tick_q;
  logic [1:0] ph_q;
  omi_bitcmd_type cmd_q;
  logic bit_q;
  logic done_q;
  logic rx_q;
  logic [`OMI_NPORTS-1:0] sel_q;
  logic [`OMI_NPORTS-1:0] scl_oe_q;
  logic [`OMI_NPORTS-1:0] sda_oe_q;

  // {scl, sda} released levels per phase
  function automatic logic [1:0] lvl(omi_bitcmd_type c, logic [1:0] p, logic b);
    logic [1:0] r;
    r = 2'b11;
    unique case (c)
      BC_START: r = (p == 2'd0) ? 2'b01 : (p == 2'd1) ? 2'b11 : (p == 2'd2) ? 2'b10 : 2'b00;
      BC_STOP: r = (p == 2'd0) ? 2'b00 : (p == 2'd1) ? 2'b10 : 2'b11;
      BC_WRITE: r = {(p == 2'd1) || (p == 2'd2), b};
      BC_READ: r = {(p == 2'd1) || (p == 2'd2), 1'b1};
    endcase
    return r;
  endfunction

  wire tick_end = busy_q && (tick_q == QTR_LAST);
  wire [1:0] ph_next = ph_q + 2'd1;
  wire [`OMI_NPORTS-1:0] sel_new = `OMI_NPORTS'(1) << tw.port;
  wire [1:0] lv_first = lvl(tw.cmd, 2'd0, tw.txbit);
  wire [1:0] lv_next = lvl(cmd_q, ph_next, bit_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      tick_q <= 8'h00;
      ph_q <= 2'd0;
      cmd_q <= BC_STOP;
      bit_q <= 1'b1;
      done_q <= 1'b0;
      rx_q <= 1'b1;
      sel_q <= '0;
      scl_oe_q <= '0;
      sda_oe_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && tw.req) begin
        busy_q <= 1'b1;
        cmd_q <= tw.cmd;
        bit_q <= tw.txbit;
        ph_q <= 2'd0;
        tick_q <= 8'h00;
        sel_q <= sel_new;
        scl_oe_q <= lv_first[1] ? '0 : sel_new;
        sda_oe_q <= lv_first[0] ? '0 : sel_new;
      end else if (tick_end) begin
        tick_q <= 8'h00;
        ph_q <= ph_next;
        if (ph_q == 2'd2) begin
          rx_q <= tw.sda_line;
        end
        if (ph_q == 2'd3) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          scl_oe_q <= lv_next[1] ? '0 : sel_q;
          sda_oe_q <= lv_next[0] ? '0 : sel_q;
        end
      end else if (busy_q) begin
        tick_q <= tick_q + 8'h01;
      end
    end
  end

  assign tw.done = done_q;
  assign tw.rxbit = rx_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

endmodule // omi_twowire

// *** verification/omi_monitor.sv ***
// Purpose: port checks of omi_top
// Assumes: single pclk domain
// Notes: bind at the foot
`timescale 1ns/10ps
module omi_monitor (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // module pins and lines
  input wire logic [9:0] loss_of_signal_in,
  input wire logic [9:0] tx_fault_in,
  input wire logic [9:0] module_present_in,
  input wire logic [9:0] tx_disable,
  input wire logic [9:0] scl_out,
  input wire logic [9:0] scl_oe,
  input wire logic [9:0] sda_out,
  input wire logic [9:0] sda_oe
);
  logic [2:0] stc_q;
  logic [9:0] gap_q;
  wire mapped = paddr >= 16'h1e64 && paddr <= 16'h1e78 && paddr[1:0] == 2'h0;
  wire rd_st = pready && !pwrite && paddr == 16'h1e64;
  wire wr_ct = pready && pwrite && paddr == 16'h1e68;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // pins settled for a while, so synchroniser lag cannot matter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) stc_q <= 3'h0;
    else if (!$stable({loss_of_signal_in, tx_fault_in, module_present_in})) stc_q <= 3'h0;
    else if (stc_q != 3'h7) stc_q <= stc_q + 3'h1;
  // cycles since scl last moved
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) gap_q <= 10'h3ff;
    else if (!$stable(scl_oe)) gap_q <= 10'h0;
    else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h1;
  ////////////////////////////////////////////////////////////////////////////////
  chk_apb_wait: assert property (psel && !penable |-> ##1 !pready ##1 pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_bad_addr: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_status_live: assert property (rd_st && stc_q == 3'h7 |->
    prdata == {2'b00, loss_of_signal_in, tx_fault_in, module_present_in})
    else $error("status word differs from pins");
  chk_txdis_write: assert property (wr_ct |=> tx_disable == $past(pwdata[9:0]))
    else $error("tx disable not written");
  chk_txdis_hold: assert property (!$stable(tx_disable) |-> $past(wr_ct))
    else $error("tx disable moved without write");
  chk_ctl_read: assert property (pready && !pwrite && paddr == 16'h1e68 |->
    prdata[31:13] == 19'h0 && prdata[9:0] == tx_disable)
    else $error("control word readback wrong");
  chk_lines_low: assert property (scl_out == 10'h0 && sda_out == 10'h0)
    else $error("line data not low");
  chk_one_port: assert property ($onehot0(scl_oe | sda_oe))
    else $error("more than one port driven");
  chk_scl_spacing: assert property (!$stable(scl_oe) |-> gap_q >= 10'd249)
    else $error("scl quarter too short");
  cover property (pready && pslverr);
  cover property (rd_st && stc_q == 3'h7);
  cover property (!$stable(scl_oe));
endmodule // omi_monitor

bind omi_top omi_monitor omi_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .loss_of_signal_in, .tx_fault_in, .module_present_in,
  .tx_disable, .scl_out, .scl_oe, .sda_out, .sda_oe);

// *** verification/omi_module_model.sv ***
// Purpose: pluggable module seen on the two-wire lines
// Assumes: pull-ups on every line, only one port addressed
// Notes: acks bytes, answers a random read, may refuse on command
`timescale 1ns/10ps
module omi_module_model (
  // lines
  input wire logic pclk,
  input wire logic [9:0] scl_oe,
  input wire logic [9:0] sda_oe,
  output logic [9:0] sda_in,
  // scenario control
  input wire logic [3:0] port,
  input wire logic nak,
  input wire logic [7:0] rd_byte,
  output logic [7:0] last_byte
);
  logic scl, sda, scl_p, sda_p, first, rd, rd_next;
  logic pull = 1'b0;
  logic [3:0] bitn;
  logic [7:0] sh;
  // released lines float high through the pull-ups
  assign sda_in = ~(sda_oe | ({9'h0, pull} << port));
  assign scl = ~scl_oe[port];
  assign sda = sda_in[port];
  always @(posedge pclk) begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && scl_p && sda_p && !sda) begin
      bitn <= 4'h0;
      first <= 1'b1;
      rd <= 1'b0;
      pull <= 1'b0;
    end else if (scl && !scl_p) begin
      bitn <= bitn + 4'h1;
      sh <= {sh[6:0], sda};
    end else if (!scl && scl_p) begin
      if (bitn == 4'h8) begin
        pull <= !rd && !nak;
        if (!rd) last_byte <= sh;
        rd_next <= first && sh[0];
        first <= 1'b0;
      end else if (bitn == 4'h9) begin
        bitn <= 4'h0;
        rd <= rd_next;
        pull <= rd_next && !rd_byte[7];
      end else if (rd) pull <= !rd_byte[3'h7 - bitn[2:0]];
    end
  end
endmodule // omi_module_model

// *** verification/testbench.sv ***
// Purpose: self-checking bench of omi_top
// Assumes: 100 MHz pclk, module model on the lines
// Notes: reads queued by the driver, checked as pready comes
`timescale 1ns/10ps
module testbench;
  localparam logic [15:0] AST = 16'h1e64, ACT = 16'h1e68, ASM = 16'h1e6c, ADT = 16'h1e70;
  localparam logic [15:0] AIS = 16'h1e74, AIM = 16'h1e78;
  localparam logic [31:0] FM = 32'h1f500000, ALL = 32'hffffffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, v, sm;
  logic pready, pslverr, irq;
  logic [9:0] los = 10'h0, fault = 10'h0, pres = 10'h0;
  logic [9:0] txdis, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic [3:0] p = 4'h0;
  logic nak = 1'b0;
  logic [7:0] rbyte = 8'h0, wbyte, lbyte;
  logic [64:0] q[$];
  logic [64:0] n;
  int errors = 0, checks = 0, cyc = 0;
  omi_top omi_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .loss_of_signal_in(los), .tx_fault_in(fault), .module_present_in(pres),
    .tx_disable(txdis), .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .irq);
  omi_module_model omi_module_model_inst (.pclk, .scl_oe, .sda_oe, .sda_in, .port(p), .nak,
    .rd_byte(rbyte), .last_byte(lbyte));
  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // holds the whole request until pready is seen high
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic e, input logic [31:0] x, input logic [31:0] m);
    int k;
    k = 0;
    q.push_back({e, x, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && k++ < 20);
    if (pready !== 1'b1) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next setup never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m);
    xfer(1'b0, a, 32'h0, 1'b0, x, m);
  endtask
  // a serial cycle ends in the finished event; no fixed length assumed
  task automatic wait_done();
    int k;
    k = 0;
    while (irq !== 1'b1 && k++ < 45000) @(posedge pclk);
    if (irq !== 1'b1) errors++;
    wr(AIS, 32'h8);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      n = q.pop_front();
      cmp({pslverr, prdata & n[31:0]}, {n[64], n[63:32] & n[31:0]});
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(31351));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(AST, 32'h0, ALL);
    rd(ACT, 32'h0, ALL);
    rd(ASM, 32'h0000d000, ALL);
    rd(ADT, 32'h0, ALL);
    xfer(1'b0, 16'h1e7c, 32'h0, 1'b1, 32'h0, ALL);
    xfer(1'b1, 16'h1e7c, 32'h1, 1'b1, 32'h0, 32'h0);
    repeat (3) begin
      v = $urandom;
      {los, fault, pres} <= v[29:0];
      repeat (6) @(posedge pclk);
      rd(AST, {2'b00, v[29:0]}, ALL);
      v = $urandom;
      wr(ACT, v);
      rd(ACT, v & 32'h1fff, ALL);
      cmp({23'h0, txdis}, {23'h0, v[9:0]});
    end
    // presence and loss classes on, fault class off
    wr(ACT, 32'h1400);
    wr(AIM, 32'hf);
    wr(AIS, 32'hf);
    rd(AIS, 32'h0, 32'hf);
    pres <= ~pres;
    fault <= ~fault;
    los <= ~los;
    repeat (6) @(posedge pclk);
    rd(AIS, 32'h5, 32'hf);
    cmp({32'h0, irq}, 33'h1);
    wr(AIM, 32'h8);
    repeat (3) @(posedge pclk);
    cmp({32'h0, irq}, 33'h0);
    wr(AIS, 32'h5);
    rd(AIS, 32'h0, 32'hf);
    // start with the enable clear is latched but launches no cycle
    wr(ASM, 32'h0100d000);
    rd(ASM, 32'h0100d000, ALL);
    rd(ASM, 32'h0000d000, ALL);
    cmp({23'h0, scl_oe | sda_oe}, 33'h0);
    wr(ASM, 32'h030ad000);
    wait_done();
    rd(ASM, 32'h13000000, FM);
    wr(ASM, 32'h03015012);
    wait_done();
    rd(ASM, 32'h0b000000, FM);
    sm = 32'h03005100 | {12'h0, 4'($urandom % 10), 16'h0} | 32'($urandom % 256);
    p <= sm[19:16];
    wbyte = 8'($urandom);
    rbyte <= 8'($urandom);
    wr(ADT, {8'h0, wbyte, 16'h0});
    wr(ASM, sm);
    wait_done();
    rd(ASM, 32'h03400000, FM);
    cmp({25'h0, lbyte}, {25'h0, wbyte});
    wr(ASM, sm | 32'h8000);
    wait_done();
    rd(ASM, 32'h03100000, FM);
    rd(ADT, {8'h0, wbyte, 8'h0, rbyte}, ALL);
    nak <= 1'b1;
    wr(ASM, sm | 32'h8000);
    wait_done();
    rd(ASM, 32'h07000000, FM);
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule // testbench
